// >>> rtl/uctx_fifo.sv
// character buffer between the load side and the serializer
`timescale 1ns/1ps
`default_nettype none
module uctx_fifo
  import uctx_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic empty
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign empty = (wr_q == rd_q);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];

  // ****************************************
  // pointers; storage needs no reset
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (clr)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// >>> rtl/uctx_pkg.sv
// constants and types for the character-format transmitter
// ****************************************
// Functional notes
// ****************************************
package uctx_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [2:0] LEN_BASE_LAST = 3'h4;
  localparam logic [1:0] FMT_LEN_RST = 2'h0;
  localparam logic FMT_OFF_RST = 1'b0;
  localparam logic FMT_EVEN_RST = 1'b0;
  localparam logic FMT_TWO_RST = 1'b0;
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;
  localparam int unsigned SYNC_W = 17;
  // idle pin levels, load strobe high, so no false load edge after reset
  localparam logic [SYNC_W-1:0] SYNC_RST = 17'h02000;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} uctx_state_e;
endpackage

// >>> rtl/uctx_top.sv
// character-format transmitter: pin capture, format register, buffer, serializer
`timescale 1ns/1ps
`default_nettype none
module uctx_top
  import uctx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic master_clear,
  input wire logic tx_bit_clock_16x,
  input wire logic [7:0] tx_parallel_in,
  input wire logic tx_load_strobe_n,
  input wire logic ctrl_strobe,
  input wire logic parity_disable,
  input wire logic even_parity_select,
  input wire logic two_stop_select,
  input wire logic char_len_hi,
  input wire logic char_len_lo,
  input wire logic rx_parity_mismatch,
  output logic serial_out,
  output logic char_done,
  output logic tx_holding_empty,
  output logic fmt_parity_off,
  output logic fmt_even_parity,
  output logic fmt_two_stop,
  output logic [1:0] fmt_char_len,
  output logic rx_parity_error
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  wire [SYNC_W-1:0] pins = {master_clear, tx_bit_clock_16x, ctrl_strobe, tx_load_strobe_n,
                            parity_disable, even_parity_select, two_stop_select,
                            char_len_hi, char_len_lo, tx_parallel_in};
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end
  wire [7:0] data_s = sync2_q[7:0];
  wire [1:0] len_s = sync2_q[9:8];
  wire two_s = sync2_q[10];
  wire even_s = sync2_q[11];
  wire off_s = sync2_q[12];
  wire load_n_s = sync2_q[13];
  wire ctl_s = sync2_q[14];
  wire bclk_s = sync2_q[15];
  wire mclr_s = sync2_q[16];

  // ****************************************
  // edge detection
  // ****************************************
  logic load_prev_q;
  logic bclk_prev_q;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      load_prev_q <= 1'b1;
      bclk_prev_q <= 1'b0;
    end
    else
    begin
      load_prev_q <= load_n_s;
      bclk_prev_q <= bclk_s;
    end
  end
  // trailing edge of the low load pulse
  wire load_rise = load_n_s && !load_prev_q;
  // bit clock is slow against mclk, so one tick per rising edge
  wire tick = bclk_s && !bclk_prev_q;

  // ****************************************
  // format register
  // ****************************************
  logic [1:0] fmt_len_q;
  logic fmt_off_q;
  logic fmt_even_q;
  logic fmt_two_q;
  logic rx_perr_q;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fmt_len_q <= FMT_LEN_RST;
      fmt_off_q <= FMT_OFF_RST;
      fmt_even_q <= FMT_EVEN_RST;
      fmt_two_q <= FMT_TWO_RST;
      rx_perr_q <= 1'b0;
    end
    else if (mclr_s)
    begin
      fmt_len_q <= FMT_LEN_RST;
      fmt_off_q <= FMT_OFF_RST;
      fmt_even_q <= FMT_EVEN_RST;
      fmt_two_q <= FMT_TWO_RST;
      rx_perr_q <= 1'b0;
    end
    else
    begin
      // level sensitive: follows the inputs while the strobe is high
      if (ctl_s)
      begin
        fmt_len_q <= len_s;
        fmt_off_q <= off_s;
        fmt_even_q <= even_s;
        fmt_two_q <= two_s;
      end
      rx_perr_q <= rx_parity_mismatch && !fmt_off_q;
    end
  end
  assign fmt_char_len = fmt_len_q;
  assign fmt_parity_off = fmt_off_q;
  assign fmt_even_parity = fmt_even_q;
  assign fmt_two_stop = fmt_two_q;
  assign rx_parity_error = rx_perr_q;

  // ****************************************
  // holding buffer
  // ****************************************
  logic f_valid;
  logic f_ready;
  logic f_in_ready;
  logic f_empty;
  logic [7:0] f_data;
  uctx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .clr(mclr_s),
    .in_valid(load_rise),
    .in_ready(f_in_ready),
    .in_data(data_s),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data),
    .empty(f_empty)
  );
  // a load into a full buffer is dropped, so empty means room left
  assign tx_holding_empty = f_in_ready;

  // ****************************************
  // serializer
  // ****************************************
  wire [2:0] live_last = LEN_BASE_LAST + {1'b0, fmt_len_q};
  logic [7:0] len_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_mask
      assign len_mask[gi] = (3'(gi) <= live_last);
    end
  endgenerate
  wire [7:0] load_bits = f_data & len_mask;
  // odd parity makes the total count of ones odd
  wire load_par = (^load_bits) ^ !fmt_even_q;

  uctx_state_e state_q, state_d;
  logic [3:0] tick_cnt_q, tick_cnt_d;
  logic [2:0] bit_q, bit_d;
  logic [2:0] cur_last_q, cur_last_d;
  logic cur_off_q, cur_off_d;
  logic cur_two_q, cur_two_d;
  logic stop_q, stop_d;
  logic par_q, par_d;
  logic [7:0] shift_q, shift_d;
  logic done_q, done_d;
  logic line_q, line_d;
  wire bit_end = tick && (tick_cnt_q == TICK_LAST);

  always_comb
  begin
    state_d = state_q;
    tick_cnt_d = tick_cnt_q;
    bit_d = bit_q;
    cur_last_d = cur_last_q;
    cur_off_d = cur_off_q;
    cur_two_d = cur_two_q;
    stop_d = stop_q;
    par_d = par_q;
    shift_d = shift_q;
    done_d = done_q;
    f_ready = 1'b0;
    if (tick && state_q != ST_IDLE)
      tick_cnt_d = tick_cnt_q + 4'h1;
    case (state_q)
      ST_IDLE:
        if (tick && f_valid)
        begin
          // format is frozen per character so a strobe mid-frame is harmless
          f_ready = 1'b1;
          state_d = ST_START;
          tick_cnt_d = 4'h0;
          shift_d = load_bits;
          par_d = load_par;
          cur_last_d = live_last;
          cur_off_d = fmt_off_q;
          cur_two_d = fmt_two_q;
          done_d = 1'b0;
        end
      ST_START:
        if (bit_end)
        begin
          state_d = ST_DATA;
          bit_d = 3'h0;
        end
      ST_DATA:
        if (bit_end)
        begin
          if (bit_q == cur_last_q)
          begin
            state_d = cur_off_q ? ST_STOP : ST_PAR;
            stop_d = 1'b0;
          end
          else
          begin
            bit_d = bit_q + 3'h1;
            shift_d = {1'b0, shift_q[7:1]};
          end
        end
      ST_PAR:
        if (bit_end)
        begin
          state_d = ST_STOP;
          stop_d = 1'b0;
        end
      ST_STOP:
        if (bit_end)
        begin
          if (cur_two_q && !stop_q)
            stop_d = 1'b1;
          else
          begin
            state_d = ST_IDLE;
            done_d = 1'b1;
          end
        end
      default:
        state_d = ST_IDLE;
    endcase
  end

  assign line_d = (state_d == ST_START) ? LINE_SPACE :
                  (state_d == ST_DATA) ? shift_d[0] :
                  (state_d == ST_PAR) ? par_d : LINE_MARK;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst || mclr_s)
    begin
      state_q <= ST_IDLE;
      tick_cnt_q <= 4'h0;
      bit_q <= 3'h0;
      cur_last_q <= LEN_BASE_LAST;
      cur_off_q <= 1'b0;
      cur_two_q <= 1'b0;
      stop_q <= 1'b0;
      par_q <= 1'b0;
      shift_q <= 8'h00;
      done_q <= 1'b1;
      line_q <= LINE_MARK;
    end
    else
    begin
      state_q <= state_d;
      tick_cnt_q <= tick_cnt_d;
      bit_q <= bit_d;
      cur_last_q <= cur_last_d;
      cur_off_q <= cur_off_d;
      cur_two_q <= cur_two_d;
      stop_q <= stop_d;
      par_q <= par_d;
      shift_q <= shift_d;
      done_q <= done_d;
      line_q <= line_d;
    end
  end
  assign serial_out = line_q;
  assign char_done = done_q;

  // ****************************************
  // checks
  // ****************************************
  idle_mark_a: assert property (@(posedge mclk) disable iff (rst) (state_q == ST_IDLE) |-> line_q)
    else $error("line not high while idle");
  start_space_a: assert property (@(posedge mclk) disable iff (rst) (state_q == ST_START) |-> !line_q && !done_q)
    else $error("start bit not low");
  bit_hold_a: assert property (@(posedge mclk) disable iff (rst)
    ($changed(line_q) && !$past(mclr_s)) |-> $past(tick) && ($past(tick_cnt_q) == TICK_LAST || $past(state_q) == ST_IDLE))
    else $error("line changed off a bit boundary");
  no_parity_a: assert property (@(posedge mclk) disable iff (rst) cur_off_q |-> state_q != ST_PAR)
    else $error("parity bit sent while disabled");
  parity_value_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_PAR) |-> line_q == ((^shift_q[0]) ^ par_q ^ shift_q[0]))
    else $error("parity bit wrong");
  data_len_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_DATA && bit_end && bit_q == cur_last_q && !mclr_s) |=> state_q == (cur_off_q ? ST_STOP : ST_PAR))
    else $error("data field length wrong");
  two_stop_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == ST_STOP && bit_end && cur_two_q && !stop_q && !mclr_s) |=> state_q == ST_STOP && line_q && stop_q)
    else $error("second stop bit missing");
  done_fall_a: assert property (@(posedge mclk) disable iff (rst) $fell(done_q) |-> $fell(line_q))
    else $error("done dropped off the start edge");
  fmt_latch_a: assert property (@(posedge mclk) disable iff (rst)
    (ctl_s && !mclr_s) |=> fmt_char_len == $past(len_s) && fmt_parity_off == $past(off_s))
    else $error("format not captured");
  clear_out_a: assert property (@(posedge mclk) disable iff (rst) mclr_s |=> line_q && done_q && tx_holding_empty)
    else $error("master clear outputs wrong");
  empty_room_a: assert property (@(posedge mclk) disable iff (rst) f_empty |-> tx_holding_empty)
    else $error("holding empty low with room");
endmodule
`default_nettype wire

// >>> tb/uctx_partner.sv
// far-side model: 16x bit clock source and mid-bit sampling serial receiver
`timescale 1ns/1ps
`default_nettype none
module uctx_partner
(
  input wire logic mclk,
  input wire logic serial_out,
  input wire logic char_done,
  input wire logic [3:0] frame_len,
  output logic tx_bit_clock_16x,
  output logic [11:0] frame,
  output logic frame_valid,
  output logic start_ok,
  output logic [7:0] done_hi
);
  logic prev;
  logic [7:0] done_cnt;
  initial
  begin
    tx_bit_clock_16x = 1'b0;
    frame_valid = 1'b0;
    start_ok = 1'b0;
    frame = '1;
    prev = 1'b1;
    done_cnt = 8'h00;
    done_hi = 8'h00;
  end
  // free running, four mclk periods, so one bit spans 64 mclk
  always #40 tx_bit_clock_16x = ~tx_bit_clock_16x;
  // high time of done ahead of each start edge
  always @(posedge mclk)
    done_cnt <= (char_done === 1'b1) ? done_cnt + 8'h01 : 8'h00;
  // samples at mid-bit, so a wrong bit length drifts into the wrong bit
  always
  begin
    @(posedge mclk);
    #1;
    frame_valid = 1'b0;
    if (prev === 1'b1 && serial_out === 1'b0)
    begin
      start_ok = ~char_done;
      done_hi = done_cnt;
      frame = '1;
      repeat (32) @(posedge mclk);
      #1;
      frame[0] = serial_out;
      for (int i = 1; i < int'(frame_len); i++)
      begin
        repeat (64) @(posedge mclk);
        #1;
        frame[i] = serial_out;
      end
      frame_valid = 1'b1;
    end
    prev = serial_out;
  end
endmodule
`default_nettype wire

// >>> tb/uctx_tb_top.sv
// self-checking bench for the character-format transmitter
`timescale 1ns/1ps
`default_nettype none
module uctx_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic master_clear = 1'b0;
  logic tx_load_strobe_n = 1'b1;
  logic ctrl_strobe = 1'b0;
  logic rx_parity_mismatch = 1'b0;
  logic [7:0] tx_parallel_in = 8'h00;
  logic [4:0] fpin = 5'h00; // off, even, two, hi, lo
  logic tx_bit_clock_16x, serial_out, char_done, tx_holding_empty;
  logic fmt_parity_off, fmt_even_parity, fmt_two_stop, rx_parity_error, frame_valid, start_ok;
  logic [1:0] fmt_char_len;
  logic [11:0] frame;
  logic [7:0] done_hi;
  logic [3:0] frame_len = 4'h7;
  logic [12:0] exp_q[$];
  logic [12:0] e;
  logic ignore = 1'b0;
  logic [31:0] seed = 32'h3fd2;
  int bad_count = 0;
  int num_checks = 0;
  int rcv_count = 0;
  always #10 mclk = ~mclk;
  uctx_top DUT (.mclk(mclk), .rst(rst), .master_clear(master_clear), .tx_bit_clock_16x(tx_bit_clock_16x),
    .tx_parallel_in(tx_parallel_in), .tx_load_strobe_n(tx_load_strobe_n), .ctrl_strobe(ctrl_strobe),
    .parity_disable(fpin[4]), .even_parity_select(fpin[3]), .two_stop_select(fpin[2]), .char_len_hi(fpin[1]),
    .char_len_lo(fpin[0]), .rx_parity_mismatch(rx_parity_mismatch), .serial_out(serial_out),
    .char_done(char_done), .tx_holding_empty(tx_holding_empty), .fmt_parity_off(fmt_parity_off),
    .fmt_even_parity(fmt_even_parity), .fmt_two_stop(fmt_two_stop), .fmt_char_len(fmt_char_len),
    .rx_parity_error(rx_parity_error));
  uctx_partner partner (.mclk(mclk), .serial_out(serial_out), .char_done(char_done), .frame_len(frame_len),
    .tx_bit_clock_16x(tx_bit_clock_16x), .frame(frame), .frame_valid(frame_valid), .start_ok(start_ok),
    .done_hi(done_hi));
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] expv);
    num_checks++;
    if (seen !== expv)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // start low, data lsb first, parity seeded with one for odd
  function automatic logic [11:0] exp_frame(input logic [4:0] f, input logic [7:0] d);
    logic [11:0] w;
    logic p;
    int n;
    n = 5 + f[1:0];
    w = '1;
    w[0] = 1'b0;
    p = ~f[3];
    for (int i = 0; i < n; i++)
    begin
      w[1 + i] = d[i];
      p = p ^ d[i];
    end
    if (!f[4])
      w[1 + n] = p;
    return w;
  endfunction
  function automatic logic [3:0] flen(input logic [4:0] f);
    return 4'(6 + f[1:0] + (f[4] ? 0 : 1) + (f[2] ? 2 : 1));
  endfunction
  task automatic set_fmt(input logic [4:0] f);
    fpin = f;
    frame_len = flen(f);
    ctrl_strobe = 1'b1;
    step(5);
    ctrl_strobe = 1'b0;
    step(3);
    check("fmt", {7'h00, fmt_parity_off, fmt_even_parity, fmt_two_stop, fmt_char_len}, {7'h00, f});
  endtask
  // data held three cycles either side of the low strobe pulse
  task automatic load(input logic [7:0] d, input logic b2b, input logic keep);
    tx_parallel_in = d;
    step(3);
    tx_load_strobe_n = 1'b0;
    step(2);
    tx_load_strobe_n = 1'b1;
    step(3);
    if (keep)
      exp_q.push_back({b2b, exp_frame(fpin, d)});
  endtask
  task automatic wait_frames(input int n);
    int t;
    t = 0;
    while (rcv_count < n && t < 20000)
    begin
      step(1);
      t++;
    end
    check("frames", 12'(rcv_count), 12'(n));
  endtask
  always @(posedge mclk)
  begin
    if (frame_valid === 1'b1 && ignore === 1'b0)
    begin
      rcv_count++;
      check("queued", {11'h000, exp_q.size() > 0}, 12'h001);
      if (exp_q.size() > 0)
      begin
        e = exp_q.pop_front();
        check("frame", frame, e[11:0]);
        check("start", {11'h000, start_ok}, 12'h001);
        if (e[12])
          check("gap", {4'h0, done_hi}, 12'h004);
      end
    end
  end
  initial
  begin
    step(3);
    rst = 1'b0;
    check("idle", {9'h000, serial_out, char_done, tx_holding_empty}, 12'h007);
    check("fmt_rst", {7'h00, fmt_parity_off, fmt_even_parity, fmt_two_stop, fmt_char_len}, 12'h000);
    // every format code once, one random character each
    for (int c = 0; c < 32; c++)
    begin
      set_fmt(5'(c));
      seed = lfsr(seed);
      rx_parity_mismatch = seed[8];
      load(seed[7:0], 1'b0, 1'b1);
      check("par_err", {11'h000, rx_parity_error}, {11'h000, seed[8] & ~fpin[4]});
      wait_frames(c + 1);
    end
    fpin = 5'h0b;
    step(6);
    check("fmt_hold", {7'h00, fmt_parity_off, fmt_even_parity, fmt_two_stop, fmt_char_len}, 12'h01f);
    // one in flight plus sixteen buffered, last three refused
    set_fmt(5'h07);
    seed = lfsr(seed);
    load(seed[7:0], 1'b0, 1'b1);
    step(10);
    for (int k = 0; k < 19; k++)
    begin
      seed = lfsr(seed);
      load(seed[7:0], 1'b1, k < 16);
      if (k == 14)
        check("room", {11'h000, tx_holding_empty}, 12'h001);
    end
    check("full", {11'h000, tx_holding_empty}, 12'h000);
    wait_frames(49);
    // receiver reports at mid stop bit, so let the last stop bit finish
    step(40);
    check("drained", {9'h000, serial_out, char_done, tx_holding_empty}, 12'h007);
    // clear in mid-character, frame then discarded
    load(8'h55, 1'b0, 1'b0);
    step(200);
    ignore = 1'b1;
    master_clear = 1'b1;
    step(3);
    master_clear = 1'b0;
    step(5);
    check("clear", {4'h0, serial_out, char_done, tx_holding_empty, fmt_parity_off, fmt_even_parity, fmt_two_stop,
      fmt_char_len}, 12'h0e0);
    end_of_test;
  end
  // about 35k cycles expected, limit at 70k cycles
  initial
  begin
    #1400000;
    bad_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
